// *** verilog/enc_mon_params.svh ***
// Purpose: constants for the encoder monitor and modulo output block
// Assumes: 100 MHz mclk
// Notes:   opcodes, formats, register offsets and reset values
`ifndef ENC_MON_PARAMS_SVH
`define ENC_MON_PARAMS_SVH
`define OP_MON_ENABLE    8'haa
`define OP_MON_DISABLE   8'hab
`define OP_MOD_SET       8'hbd
`define OP_MOD_CLEAR     8'hbe
`define OP_SET_BIT       8'hd0
`define OP_CLR_BIT       8'hce
`define OP_CFG_IO        8'hbc
`define FMT_QUAD         2'h0
`define FMT_UPDN         2'h1
`define FMT_STEPDIR      2'h2
`define SRC_INTERNAL     1'h0
`define SRC_EXTERNAL     1'h1
`define MOD_COUNT_MIN    16'h0001
`define MOD_COUNT_MAX    16'h0020
`define REG_CMD          4'h0
`define REG_PARAM        4'h1
`define REG_STATUS       4'h2
`define REG_IRQ_STATUS   4'h3
`define REG_IRQ_MASK     4'h4
`define REG_IO_DIR       4'h5
`define REG_IO_OUT       4'h6
`define IRQ_DONE_BIT     0
`define IRQ_SEQ_BIT      1
`define IRQ_WIDTH        2
`define IO_LINES         7
`define STAT_RESET       32'h0000_0000
`endif

// *** verilog/enc_mon_pkg.sv ***
// Purpose: shared types for the encoder monitor and modulo output block
// Assumes: nothing beyond the params header
// Notes:   command word and modulo configuration travel as structs
package enc_mon_pkg;
   typedef struct packed
   {
      logic [15:0] count;
      logic        source;
      logic [1:0]  format;
   } mod_cfg_type;

   typedef struct packed
   {
      logic [7:0]  opcode;
      logic [7:0]  line;
      logic [15:0] value;
   } cmd_word_type;

   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b001,
      ST_EXEC  = 3'b010,
      ST_HALT  = 3'b100
   } cmd_state_type;
endpackage : enc_mon_pkg

// *** verilog/enc_mon_modulo.sv ***
// Purpose: encoder monitor and modulo output, commands over Avalon-MM
// Assumes: single clock mclk 100 MHz, sys_rst async active high
// Notes:   encoder pins and io inputs are synchronised by two flip-flops
// Functional notes
// R1: with monitoring on, encoder A drives io line 1, B line 2, index line 3.
// R2: with monitoring on, set or clear bit requests to lines 1-3 are a conflict.
// R3: enabling monitoring while any of lines 1-3 is an output is a conflict.
// R4: either conflict raises a sequence error and halts the command program.
// R5: monitoring ends only on the disable command, which frees lines 1-3.
// R6: enable-monitor is opcode 170 with no parameters, acknowledged without data.
// R7: modulo clear stops the modulo output and frees lines 6 and 7.
// R8: modulo clear is opcode 190 with no parameters, acknowledged only.
// R9: the host configures lines 6 and 7 as inputs before modulo set.
// R10: source 0 counts the internal encoder, source 1 an external one.
// R11: format 0 drives lines 6 and 7 as a divided quadrature pair.
// R12: format 1 pulses line 6 on positive counts and line 7 on negative counts.
// R13: format 2 pulses line 6 and drives direction on line 7.
// R14: step output rate is the encoder count rate divided by the modulo count.
// R15: modulo count is signed 16-bit, accepted range 1 to 32.
// R16: modulo set is opcode 189 carrying count, source and format, ack only.
// R17: the divider wraps after count edges and resets on modulo enable or clear.
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "enc_mon_params.svh"
module enc_mon_modulo
   import enc_mon_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   input  wire logic [3:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic                  int_enc_a,
   input  wire logic                  int_enc_b,
   input  wire logic                  int_enc_index,
   input  wire logic                  ext_enc_a,
   input  wire logic                  ext_enc_b,
   input  wire logic [`IO_LINES-1:0]  io_in,
   output logic      [`IO_LINES-1:0]  io_out,
   output logic      [`IO_LINES-1:0]  io_oe,
   output logic                       irq
);
   // synchronisers: stage one feeds stage two only
   logic [6:0] sync1;
   logic [6:0] sync2;
   logic [6:0] next_sync1;
   logic [6:0] next_sync2;
   logic [`IO_LINES-1:0] io_sync1;
   logic [`IO_LINES-1:0] io_sync2;

   always_comb
   begin
      next_sync1 = {io_in[0], ext_enc_b, ext_enc_a, int_enc_index, int_enc_b, int_enc_a, 1'b0};
      next_sync2 = sync1;
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sync1    <= 7'h00;
         sync2    <= 7'h00;
         io_sync1 <= 7'h00;
         io_sync2 <= 7'h00;
      end
      else
      begin
         sync1    <= next_sync1;
         sync2    <= next_sync2;
         io_sync1 <= io_in;
         io_sync2 <= io_sync1;
      end
   end

   logic ia;
   logic ib;
   logic ii;
   logic ea;
   logic eb;
   assign ia = sync2[1];
   assign ib = sync2[2];
   assign ii = sync2[3];
   assign ea = sync2[4];
   assign eb = sync2[5];

   // command and control state
   cmd_state_type        state;
   cmd_state_type        next_state;
   cmd_word_type         cmd;
   cmd_word_type         next_cmd;
   mod_cfg_type          cfg;
   mod_cfg_type          next_cfg;
   logic                 mon_on;
   logic                 next_mon_on;
   logic                 mod_on;
   logic                 next_mod_on;
   logic                 mod_restart;
   logic                 next_mod_restart;
   logic [`IO_LINES-1:0] dir;
   logic [`IO_LINES-1:0] next_dir;
   logic [`IO_LINES-1:0] outv;
   logic [`IO_LINES-1:0] next_outv;
   logic [15:0]          param;
   logic [15:0]          next_param;
   logic [`IRQ_WIDTH-1:0] istat;
   logic [`IRQ_WIDTH-1:0] next_istat;
   logic [`IRQ_WIDTH-1:0] imask;
   logic [`IRQ_WIDTH-1:0] next_imask;
   logic [31:0]          rdata;
   logic [31:0]          next_rdata;
   logic                 wait_q;
   logic                 next_wait_q;
   logic                 ev_done;
   logic                 ev_seq;
   logic                 line_ok;
   logic [2:0]           lidx;

   logic acc;
   assign acc = (avs_read | avs_write) & wait_q;
   assign lidx = cmd.line[2:0] - 3'h1;

   always_comb
   begin
      next_state       = state;
      next_cmd         = cmd;
      next_cfg         = cfg;
      next_mon_on      = mon_on;
      next_mod_on      = mod_on;
      next_mod_restart = 1'b0;
      next_dir         = dir;
      next_outv        = outv;
      next_param       = param;
      next_imask       = imask;
      next_rdata       = rdata;
      next_wait_q      = 1'b1;
      ev_done          = 1'b0;
      ev_seq           = 1'b0;
      line_ok          = (cmd.line >= 8'h01) && (cmd.line <= 8'h07);
      // one wait cycle per access, then the answer
      if (acc)
         next_wait_q = 1'b0;
      if (acc && avs_write && avs_address == `REG_CMD && state == ST_IDLE)
      begin
         next_cmd   = avs_writedata;
         next_state = ST_EXEC;
      end
      if (acc && avs_write && avs_address == `REG_PARAM)
         next_param = avs_writedata[15:0];
      if (acc && avs_write && avs_address == `REG_IRQ_MASK)
         next_imask = avs_writedata[`IRQ_WIDTH-1:0];
      // writing the status register restarts a halted program
      if (acc && avs_write && avs_address == `REG_STATUS && state == ST_HALT)
         next_state = ST_IDLE;
      unique case (state)
         ST_IDLE:
            ;
         ST_EXEC:
         begin
            next_state = ST_IDLE;
            ev_done    = 1'b1;
            unique case (cmd.opcode)
               `OP_MON_ENABLE:
               begin
                  if (dir[2:0] != 3'h0) // see R3
                     ev_seq = 1'b1;
                  else
                     next_mon_on = 1'b1; // see R6
               end
               `OP_MON_DISABLE:
                  next_mon_on = 1'b0; // see R5
               `OP_MOD_SET:
               begin
                  // see R16
                  if ($signed(cmd.value) < $signed(`MOD_COUNT_MIN) ||
                      $signed(cmd.value) > $signed(`MOD_COUNT_MAX)) // see R15
                     ev_seq = 1'b1;
                  else
                  begin
                     next_cfg.count   = cmd.value;
                     next_cfg.source  = param[0]; // see R10
                     next_cfg.format  = param[9:8];
                     next_mod_on      = 1'b1;
                     next_mod_restart = 1'b1; // see R17
                     next_dir[6:5]    = 2'h0; // see R9
                  end
               end
               `OP_MOD_CLEAR:
               begin
                  next_mod_on      = 1'b0; // see R7 R8
                  next_mod_restart = 1'b1; // see R17
               end
               `OP_SET_BIT,
               `OP_CLR_BIT:
               begin
                  if (!line_ok || (mon_on && cmd.line <= 8'h03)) // see R2
                     ev_seq = 1'b1;
                  else
                  begin
                     next_dir[lidx]  = 1'b1;
                     next_outv[lidx] = (cmd.opcode == `OP_SET_BIT);
                  end
               end
               `OP_CFG_IO:
               begin
                  if (!line_ok || (mon_on && cmd.line <= 8'h03))
                     ev_seq = 1'b1;
                  else
                  begin
                     next_dir[lidx]  = ~cmd.value[15];
                     next_outv[lidx] = cmd.value[0];
                  end
               end
               default:
                  ev_seq = 1'b1;
            endcase
            if (ev_seq)
               next_state = ST_HALT; // see R4
         end
         ST_HALT:
            ;
         default:
            next_state = ST_IDLE;
      endcase
      unique case (avs_address)
         `REG_CMD:        next_rdata = {24'h0, cmd.opcode};
         `REG_PARAM:      next_rdata = {16'h0, param};
         `REG_STATUS:     next_rdata = {27'h0, mod_on, mon_on, state == ST_HALT,
                                        state == ST_EXEC, state == ST_IDLE};
         `REG_IRQ_STATUS: next_rdata = {30'h0, istat};
         `REG_IRQ_MASK:   next_rdata = {30'h0, imask};
         `REG_IO_DIR:     next_rdata = {25'h0, dir};
         `REG_IO_OUT:     next_rdata = {25'h0, io_sync2};
         default:         next_rdata = 32'h0;
      endcase
      // set wins over read clear
      next_istat = istat;
      if (acc && avs_read && avs_address == `REG_IRQ_STATUS)
         next_istat = '0;
      if (ev_done)
         next_istat[`IRQ_DONE_BIT] = 1'b1;
      if (ev_seq)
         next_istat[`IRQ_SEQ_BIT] = 1'b1;
   end

   // modulo divider and output generator
   logic        cnt_a;
   logic        cnt_b;
   logic        pa;
   logic        pb;
   logic [1:0]  ph;
   logic [1:0]  next_ph;
   logic [15:0] div;
   logic [15:0] next_div;
   logic [1:0]  q;
   logic [1:0]  next_q;
   logic        sq;
   logic        next_sq;
   logic        up;
   logic        next_up;
   logic        step;
   logic        fwd;
   logic [`IO_LINES-1:0] next_io_out;
   logic [`IO_LINES-1:0] next_io_oe;

   assign cnt_a = (cfg.source == `SRC_EXTERNAL) ? ea : ia; // see R10
   assign cnt_b = (cfg.source == `SRC_EXTERNAL) ? eb : ib;

   always_comb
   begin
      next_ph  = {cnt_a, cnt_b};
      step     = (ph != {cnt_a, cnt_b});
      // gray order 00 01 11 10 is forward
      fwd      = (ph[1] == ph[0]) ? (cnt_b != ph[0]) : (cnt_a != ph[1]);
      next_div = div;
      next_q   = q;
      next_sq  = sq;
      next_up  = up;
      if (mod_restart || !mod_on)
      begin
         next_div = 16'h0; // see R17
         next_q   = 2'h0;
         next_sq  = 1'b0;
      end
      else if (step)
      begin
         next_up = fwd;
         if (div + 16'h1 >= cfg.count) // see R14
         begin
            next_div = 16'h0;
            next_sq  = 1'b1;
            next_q   = fwd ? q + 2'h1 : q - 2'h1;
         end
         else
         begin
            next_div = div + 16'h1;
            // one period per wrap: low for the second half, and on a reversal
            if (div + 16'h1 >= (cfg.count >> 1) || fwd != up)
               next_sq = 1'b0;
         end
      end
      else if (cfg.count == 16'h1)
         next_sq = 1'b0; // divide by one: one clock pulse per count
      next_io_oe  = dir;
      next_io_out = outv;
      if (mon_on)
      begin
         next_io_oe[2:0]  = 3'h7; // see R1
         next_io_out[2:0] = {ii, ib, ia};
      end
      if (mod_on)
      begin
         next_io_oe[6:5] = 2'h3;
         unique case (cfg.format)
            `FMT_QUAD:    next_io_out[6:5] = {q[1], q[1] ^ q[0]}; // see R11
            `FMT_UPDN:    next_io_out[6:5] = {sq & ~up, sq & up}; // see R12
            `FMT_STEPDIR: next_io_out[6:5] = {up, sq}; // see R13
            default:      next_io_out[6:5] = 2'h0;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state           <= ST_IDLE;
         cmd             <= '0;
         cfg             <= '0;
         mon_on          <= 1'b0;
         mod_on          <= 1'b0;
         mod_restart     <= 1'b0;
         dir             <= 7'h00;
         outv            <= 7'h00;
         param           <= 16'h0;
         istat           <= '0;
         imask           <= '0;
         rdata           <= `STAT_RESET;
         wait_q          <= 1'b1;
         ph              <= 2'h0;
         div             <= 16'h0;
         q               <= 2'h0;
         sq              <= 1'b0;
         up              <= 1'b1;
         io_out          <= 7'h00;
         io_oe           <= 7'h00;
         irq             <= 1'b0;
         avs_readdata    <= 32'h0;
         avs_waitrequest <= 1'b1;
      end
      else
      begin
         state           <= next_state;
         cmd             <= next_cmd;
         cfg             <= next_cfg;
         mon_on          <= next_mon_on;
         mod_on          <= next_mod_on;
         mod_restart     <= next_mod_restart;
         dir             <= next_dir;
         outv            <= next_outv;
         param           <= next_param;
         istat           <= next_istat;
         imask           <= next_imask;
         rdata           <= next_rdata;
         wait_q          <= next_wait_q;
         ph              <= next_ph;
         div             <= next_div;
         q               <= next_q;
         sq              <= next_sq;
         up              <= next_up;
         io_out          <= next_io_out;
         io_oe           <= next_io_oe;
         irq             <= |(next_istat & next_imask);
         avs_readdata    <= next_rdata;
         avs_waitrequest <= next_wait_q;
      end
   end

   // checks
   sequence mon_cmd_s;
      state == ST_EXEC && cmd.opcode == `OP_MON_ENABLE;
   endsequence

   AST_MON_CONFLICT: assert property (@(posedge mclk) disable iff (sys_rst) // see R3
      mon_cmd_s and dir[2:0] != 3'h0 |=> state == ST_HALT && !mon_on)
      else $error("monitor enable with output lines not rejected");
   AST_MON_DRIVE: assert property (@(posedge mclk) disable iff (sys_rst) // see R1
      mon_on |=> io_oe[2:0] == 3'h7)
      else $error("monitor lines not driven");
   AST_BIT_CONFLICT: assert property (@(posedge mclk) disable iff (sys_rst) // see R2
      state == ST_EXEC && mon_on && cmd.line >= 8'h01 && cmd.line <= 8'h03 &&
      (cmd.opcode == `OP_SET_BIT || cmd.opcode == `OP_CLR_BIT)
      |=> state == ST_HALT && $stable(dir))
      else $error("bit request on monitored line accepted");
   AST_SEQ_IRQ: assert property (@(posedge mclk) disable iff (sys_rst) // see R4
      ev_seq |=> istat[`IRQ_SEQ_BIT])
      else $error("sequence error not flagged");
   AST_MON_HOLD: assert property (@(posedge mclk) disable iff (sys_rst) // see R5
      mon_on && !(state == ST_EXEC && cmd.opcode == `OP_MON_DISABLE) |=> mon_on)
      else $error("monitor mode left without disable");
   AST_MOD_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst) // see R7
      state == ST_EXEC && cmd.opcode == `OP_MOD_CLEAR |=> ##1 io_oe[6:5] == dir[6:5])
      else $error("modulo lines not freed");
   AST_COUNT_RANGE: assert property (@(posedge mclk) disable iff (sys_rst) // see R15
      mod_on |-> cfg.count >= 16'h1 && cfg.count <= 16'h20)
      else $error("modulo count out of range");
   AST_DIV_WRAP: assert property (@(posedge mclk) disable iff (sys_rst) // see R17
      mod_on |-> div < cfg.count)
      else $error("divider past modulo count");
endmodule : enc_mon_modulo

// *** verif/enc_partner.sv ***
// Purpose: incremental encoder model driving quadrature and index pins
// Assumes: one step every 8 mclk cycles, far slower than the input sync
// Notes:   pins stand still between bursts, like a shaft at rest
`timescale 1ns/1ns
module enc_partner
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        go,
   input  wire logic        dir,
   input  wire logic [15:0] steps,
   output logic             a,
   output logic             b,
   output logic             idx,
   output logic             busy
);
   logic [15:0] left;
   logic [2:0]  tick;
   logic [1:0]  ph;
   logic [7:0]  pos;
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         left <= 16'h0000;
         tick <= 3'h0;
         ph   <= 2'h0;
         pos  <= 8'h00;
      end
      else if (go)
      begin
         left <= steps;
         tick <= 3'h0;
      end
      else if (left != 16'h0000)
      begin
         tick <= tick + 3'h1;
         if (tick == 3'h7)
         begin
            left <= left - 16'h0001;
            ph   <= dir ? ph - 2'h1 : ph + 2'h1;
            pos  <= dir ? pos - 8'h01 : pos + 8'h01;
         end
      end
   end
   // gray sequence so only one pin moves per count
   assign a    = ph[1];
   assign b    = ph[1] ^ ph[0];
   assign idx  = (pos[7:2] == 6'h00) & a & b;
   assign busy = go | (left != 16'h0000);
endmodule : enc_partner

// *** verif/tb.sv ***
// Purpose: self-checking bench for the monitor and modulo block
// Assumes: read notes queued by the bus driver, checked by a monitor
// Notes:   io lines have pull-ups when nothing drives them
`timescale 1ns/1ns
`include "enc_mon_params.svh"
`define CHK(nm, e, g) begin checked++; if ((e) !== (g)) begin err_total++; \
   $display("Error %s exp %h got %h", nm, e, g); end end
module tb;
   import enc_mon_pkg::*;
   logic        mclk, sys_rst, avs_read, avs_write, rd_on, irq;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic        avs_waitrequest;
   logic [6:0]  io_in, io_out, io_oe, po;
   logic        ia, ib, ix, ibusy, ea, eb, ebusy, gi, ge, dir, l7;
   logic [15:0] stp;
   logic [63:0] q[$];
   int          err_total, checked, up6, up7, tg, s6, s7, st, n, k, src, fmt;
   logic [7:0]  n_op[2] = '{`OP_SET_BIT, `OP_CLR_BIT};
   enc_mon_modulo uut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .int_enc_a(ia),
      .int_enc_b(ib), .int_enc_index(ix), .ext_enc_a(ea), .ext_enc_b(eb),
      .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .irq(irq));
   enc_partner pi (.mclk(mclk), .sys_rst(sys_rst), .go(gi), .dir(dir), .steps(stp),
      .a(ia), .b(ib), .idx(ix), .busy(ibusy));
   enc_partner pe (.mclk(mclk), .sys_rst(sys_rst), .go(ge), .dir(dir), .steps(stp),
      .a(ea), .b(eb), .idx(), .busy(ebusy));
   assign io_in = (io_oe & io_out) | ~io_oe;
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      po  <= io_out;
      up6 <= up6 + int'(io_out[5] & ~po[5]);
      up7 <= up7 + int'(io_out[6] & ~po[6]);
      tg  <= tg + int'(io_out[5] ^ po[5]) + int'(io_out[6] ^ po[6]);
      if (rd_on && avs_waitrequest === 1'b0)
      begin : pop_note
         logic [63:0] nt;
         nt = q.pop_front();
         `CHK("readdata", nt[63:32] & nt[31:0], avs_readdata & nt[31:0])
      end
   end
   task automatic conclude;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= ~w;
      rd_on         <= ~w;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      rd_on     <= 1'b0;
      @(posedge mclk);
   endtask : bus
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      q.push_back({e, m});
      bus(1'b0, a, 32'h0);
   endtask : rd
   task automatic cmd(input logic [7:0] op, input logic [7:0] ln, input logic [15:0] v);
      bus(1'b1, `REG_CMD, {op, ln, v});
      repeat (6) @(posedge mclk);
   endtask : cmd
   task automatic halted;
      rd(`REG_STATUS, 32'h4, 32'h4);
      `CHK("irq", 1'b1, irq)
      rd(`REG_IRQ_STATUS, 32'h2, 32'h2);
      repeat (2) @(posedge mclk);
      `CHK("irq", 1'b0, irq)
      bus(1'b1, `REG_STATUS, 32'h0);
   endtask : halted
   task automatic spin(input logic d, input logic [15:0] s);
      dir <= d;
      stp <= s;
      if (src == 0) gi <= 1'b1; else ge <= 1'b1;
      @(posedge mclk);
      gi <= 1'b0;
      ge <= 1'b0;
      @(posedge mclk);
      while (ibusy || ebusy) @(posedge mclk);
      repeat (10) @(posedge mclk);
   endtask : spin
   initial
   begin
      sys_rst = 1'b1;
      {avs_read, avs_write, rd_on, gi, ge, dir} = 6'h00;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      stp = 16'h0;
      {err_total, checked, up6, up7, tg, src} = '0;
      po = 7'h00;
      void'($urandom(41));
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      `CHK("io_oe", 7'h00, io_oe)
      rd(`REG_IRQ_MASK, 32'h0, 32'hffffffff);
      rd(4'hf, 32'h0, 32'hffffffff);
      bus(1'b1, `REG_IRQ_MASK, 32'h2);
      cmd(`OP_MON_ENABLE, 8'h0, 16'h0);
      rd(`REG_IRQ_STATUS, 32'h1, 32'h1);
      repeat (6)
      begin
         spin(1'($urandom), 16'h1);
         `CHK("mon", {3'h7, ix, ib, ia}, {io_oe[2:0], io_out[2:0]})
      end
      foreach (n_op[i])
      begin
         cmd(n_op[i], 8'(1 + $urandom % 3), 16'h0);
         halted();
      end
      cmd(`OP_MON_DISABLE, 8'h0, 16'h0);
      `CHK("io_oe", 3'h0, io_oe[2:0])
      cmd(`OP_CFG_IO, 8'h1, 16'h0000);
      cmd(`OP_MON_ENABLE, 8'h0, 16'h0);
      rd(`REG_STATUS, 32'h0, 32'h8);
      halted();
      cmd(`OP_CFG_IO, 8'h1, 16'h8000);
      for (fmt = 0; fmt < 3; fmt++)
         for (src = 0; src < 2; src++)
         begin
            n = 1 + $urandom % 32;
            k = 2 + $urandom % 3;
            cmd(`OP_CFG_IO, 8'h6, 16'h8000);
            cmd(`OP_CFG_IO, 8'h7, 16'h8000);
            bus(1'b1, `REG_PARAM, 32'(fmt << 8 | src));
            cmd(`OP_MOD_SET, 8'h0, 16'(n));
            `CHK("io_oe", 2'h3, io_oe[6:5])
            {s6, s7, st} = {up6, up7, tg};
            spin(1'b0, 16'(n * k));
            l7 = io_out[6];
            if (fmt == 0) `CHK("quad", k, tg - st)
            else `CHK("step", k, up6 - s6)
            if (fmt == 1) `CHK("down", 0, up7 - s7)
            {s6, s7} = {up6, up7};
            spin(1'b1, 16'(n * k));
            if (fmt == 1) `CHK("down", k, up7 - s7)
            if (fmt == 1) `CHK("up", 0, up6 - s6)
            if (fmt == 2) `CHK("dir", ~l7, io_out[6])
            cmd(`OP_MOD_CLEAR, 8'h0, 16'h0);
            `CHK("io_oe", 2'h0, io_oe[6:5])
         end
      cmd(`OP_MOD_SET, 8'h0, 16'h0000);
      halted();
      cmd(`OP_MOD_SET, 8'h0, 16'h0021);
      halted();
      conclude();
   end
   initial
   begin
      repeat (60000) @(posedge mclk);
      err_total++;
      conclude();
   end
endmodule : tb
